// ===== core/mmox_core.sv
`timescale 1ns/100ps
`include "mmox_defs.svh"
module mmox_core #(
  parameter int RAM_DEPTH = 128
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire mmox_pkg::mmox_instr_t instr,
  output logic instr_ready,
  output logic done,
  output logic illegal,
  output logic code_rd,
  output logic [15:0] code_addr,
  input wire logic code_valid,
  input wire logic [7:0] code_data,
  output logic [7:0] low_port_out,
  output logic low_port_oe_n,
  input wire logic [7:0] low_port_in,
  output logic [7:0] high_port_out,
  output logic addr_latch,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] acc,
  output logic [7:0] aux_b,
  output logic [7:0] psw,
  output logic [15:0] data_pointer,
  output logic [15:0] pc
);
  localparam int AW = $clog2(RAM_DEPTH);
  ////////////////////////////////////////////////////////////////////////
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] pin_s1;
  logic [7:0] pin_s2;
  logic [7:0] pin_s3;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
      pin_s3 <= 8'h00;
    end else begin
      pin_s1 <= low_port_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  mmox_pkg::mmox_state_t state, next_state;
  mmox_pkg::mmox_instr_t ir, next_ir;
  logic [7:0] ram [RAM_DEPTH];
  logic [7:0] next_ram [RAM_DEPTH];
  logic [7:0] lp_latch, next_lp_latch;
  logic [7:0] hp_latch, next_hp_latch;
  logic [3:0] cnt, next_cnt;
  logic [7:0] next_acc, next_aux_b, next_psw;
  logic [15:0] next_data_pointer, next_pc;
  logic next_instr_ready, next_done, next_illegal;
  logic next_code_rd;
  logic [15:0] next_code_addr;
  logic [7:0] next_low_port_out, next_high_port_out;
  logic next_low_port_oe_n, next_addr_latch, next_rd_n, next_wr_n;

  function automatic mmox_pkg::mmox_op_t op_of(input logic [7:0] o);
    if ((o & `MASK_RI) == `OPC_MOV_IR_DIR) return mmox_pkg::OP_IR_DIR;
    if ((o & `MASK_RI) == `OPC_MOV_IR_IMM) return mmox_pkg::OP_IR_IMM;
    if ((o & `MASK_RI) == `OPC_XRD_RI) return mmox_pkg::OP_XRD_RI;
    if ((o & `MASK_RI) == `OPC_XWR_RI) return mmox_pkg::OP_XWR_RI;
    if ((o & `MASK_RI) == `OPC_OR_A_RI) return mmox_pkg::OP_OR_RI;
    if ((o & `MASK_RN) == `OPC_OR_A_RN) return mmox_pkg::OP_OR_RN;
    unique case (o)
      `OPC_MOV_C_BIT: return mmox_pkg::OP_C_BIT;
      `OPC_MOV_BIT_C: return mmox_pkg::OP_BIT_C;
      `OPC_MOV_DP: return mmox_pkg::OP_DP;
      `OPC_CODE_DP: return mmox_pkg::OP_CODE_DP;
      `OPC_CODE_PC: return mmox_pkg::OP_CODE_PC;
      `OPC_XRD_DP: return mmox_pkg::OP_XRD_DP;
      `OPC_XWR_DP: return mmox_pkg::OP_XWR_DP;
      `OPC_MUL: return mmox_pkg::OP_MUL;
      `OPC_NOP: return mmox_pkg::OP_NOP;
      `OPC_OR_A_DIR: return mmox_pkg::OP_OR_DIR;
      `OPC_OR_A_IMM: return mmox_pkg::OP_OR_IMM;
      `OPC_OR_DIR_A: return mmox_pkg::OP_OR_DA;
      `OPC_OR_DIR_IMM: return mmox_pkg::OP_OR_DI;
      default: return mmox_pkg::OP_BAD;
    endcase
  endfunction

  // cycles per instruction
  function automatic logic [3:0] cycles_of(input mmox_pkg::mmox_op_t p);
    unique case (p)
      mmox_pkg::OP_MUL: return 4'h4;
      mmox_pkg::OP_IR_DIR, mmox_pkg::OP_BIT_C, mmox_pkg::OP_DP,
      mmox_pkg::OP_OR_DI: return 4'h2;
      default: return 4'h1;
    endcase
  endfunction

  function automatic logic [15:0] len_of(input mmox_pkg::mmox_op_t p);
    unique case (p)
      mmox_pkg::OP_DP, mmox_pkg::OP_OR_DI: return 16'h0003;
      mmox_pkg::OP_IR_DIR, mmox_pkg::OP_IR_IMM, mmox_pkg::OP_C_BIT,
      mmox_pkg::OP_BIT_C, mmox_pkg::OP_OR_DIR, mmox_pkg::OP_OR_IMM,
      mmox_pkg::OP_OR_DA: return 16'h0002;
      default: return 16'h0001;
    endcase
  endfunction

  // bank register index
  function automatic logic [AW-1:0] reg_idx(input logic [2:0] r);
    return AW'({psw[`PSW_RS_HI:`PSW_RS_LO], r});
  endfunction

  // byte reads see the port latches, never the pins
  function automatic logic [7:0] rd_dir(input logic [7:0] a);
    unique case (a)
      `SFR_ACC: return acc;
      `SFR_B: return aux_b;
      `SFR_PSW: return psw;
      `SFR_DPL: return data_pointer[7:0];
      `SFR_DPH: return data_pointer[15:8];
      `SFR_LOW_PORT: return lp_latch;
      `SFR_HIGH_PORT: return hp_latch;
      default: return (!a[7] && 32'(a) < RAM_DEPTH) ? ram[AW'(a)] : 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] bit_byte(input logic [7:0] a);
    return a[7] ? {a[7:3], 3'h0} : `BIT_RAM_BASE + {4'h0, a[6:3]};
  endfunction

  mmox_pkg::mmox_op_t op;
  logic [7:0] ri_val, rn_val, bb, bv, wd_a, wd_v, wi_a, wi_v, ex_a;
  logic wd_en, wi_en;
  logic [15:0] prod;
  assign op = op_of(ir.opcode);
  assign ri_val = ram[reg_idx({2'h0, ir.opcode[0]})];
  assign rn_val = ram[reg_idx(ir.opcode[2:0])];
  assign bb = bit_byte(ir.byte1);
  assign bv = rd_dir(bb);
  assign prod = {8'h00, acc} * {8'h00, aux_b};
  assign ex_a = (op == mmox_pkg::OP_XRD_DP || op == mmox_pkg::OP_XWR_DP) ? data_pointer[7:0] : ri_val;

  always_comb begin
    next_state = state;
    next_ir = ir;
    next_ram = ram;
    next_lp_latch = lp_latch;
    next_hp_latch = hp_latch;
    next_cnt = cnt;
    next_acc = acc;
    next_aux_b = aux_b;
    next_psw = psw;
    next_data_pointer = data_pointer;
    next_pc = pc;
    next_instr_ready = 1'b0;
    next_done = 1'b0;
    next_illegal = 1'b0;
    next_code_rd = 1'b0;
    next_code_addr = code_addr;
    next_low_port_out = lp_latch;
    next_low_port_oe_n = 1'b0;
    next_high_port_out = hp_latch;
    next_addr_latch = 1'b0;
    next_rd_n = 1'b1;
    next_wr_n = 1'b1;
    wd_en = 1'b0;
    wd_a = 8'h00;
    wd_v = 8'h00;
    wi_en = 1'b0;
    wi_a = 8'h00;
    wi_v = 8'h00;
    unique case (state)
      mmox_pkg::S_IDLE: begin
        next_instr_ready = 1'b1;
        if (instr_valid && instr_ready) begin
          next_ir = instr;
          next_instr_ready = 1'b0;
          next_cnt = cycles_of(op_of(instr.opcode)) - 4'h1;
          next_state = mmox_pkg::S_WAIT;
          unique case (op_of(instr.opcode))
            mmox_pkg::OP_CODE_DP: begin
              next_code_rd = 1'b1;
              next_code_addr = data_pointer + {8'h00, acc};
              next_state = mmox_pkg::S_CODE;
            end
            mmox_pkg::OP_CODE_PC: begin
              next_code_rd = 1'b1;
              next_code_addr = pc + 16'h0001 + {8'h00, acc};
              next_state = mmox_pkg::S_CODE;
            end
            mmox_pkg::OP_XRD_RI, mmox_pkg::OP_XRD_DP, mmox_pkg::OP_XWR_RI, mmox_pkg::OP_XWR_DP: begin
              next_state = mmox_pkg::S_XADR;
            end
            default: begin
            end
          endcase
        end
      end
      mmox_pkg::S_WAIT: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h0) begin
          next_done = 1'b1;
          next_instr_ready = 1'b1;
          next_state = mmox_pkg::S_IDLE;
          next_pc = pc + len_of(op);
          unique case (op)
            mmox_pkg::OP_IR_DIR: begin
              wi_en = 1'b1;
              wi_a = ri_val;
              wi_v = rd_dir(ir.byte1);
            end
            mmox_pkg::OP_IR_IMM: begin
              wi_en = 1'b1;
              wi_a = ri_val;
              wi_v = ir.byte1;
            end
            mmox_pkg::OP_C_BIT: next_psw[`PSW_CY] = bv[ir.byte1[2:0]];
            mmox_pkg::OP_BIT_C: begin
              wd_en = 1'b1;
              wd_a = bb;
              wd_v = bv;
              wd_v[ir.byte1[2:0]] = psw[`PSW_CY];
            end
            mmox_pkg::OP_DP: next_data_pointer = {ir.byte1, ir.byte2};
            mmox_pkg::OP_MUL: begin
              next_acc = prod[7:0];
              next_aux_b = prod[15:8];
              next_psw[`PSW_OV] = |prod[15:8];
              next_psw[`PSW_CY] = 1'b0;
            end
            mmox_pkg::OP_OR_RN: next_acc = acc | rn_val;
            mmox_pkg::OP_OR_DIR: next_acc = acc | rd_dir(ir.byte1);
            mmox_pkg::OP_OR_RI: next_acc = acc | (32'(ri_val) < RAM_DEPTH ? ram[AW'(ri_val)] : 8'h00);
            mmox_pkg::OP_OR_IMM: next_acc = acc | ir.byte1;
            mmox_pkg::OP_OR_DA, mmox_pkg::OP_OR_DI: begin
              wd_en = 1'b1;
              wd_a = ir.byte1;
              wd_v = rd_dir(ir.byte1) | (op == mmox_pkg::OP_OR_DA ? acc : ir.byte2);
            end
            mmox_pkg::OP_BAD: next_illegal = 1'b1;
            default: begin
            end
          endcase
        end
      end
      mmox_pkg::S_CODE: begin
        if (code_valid) begin
          next_acc = code_data;
          next_pc = pc + 16'h0001;
          next_done = 1'b1;
          next_instr_ready = 1'b1;
          next_state = mmox_pkg::S_IDLE;
        end
      end
      mmox_pkg::S_XADR: begin
        next_low_port_out = ex_a;
        if (op == mmox_pkg::OP_XRD_DP || op == mmox_pkg::OP_XWR_DP) begin
          next_high_port_out = data_pointer[15:8];
        end
        next_addr_latch = 1'b1;
        next_cnt = `XM_STROBE;
        next_state = mmox_pkg::S_XDAT;
      end
      mmox_pkg::S_XDAT: begin
        next_high_port_out = high_port_out;
        if (op == mmox_pkg::OP_XWR_RI || op == mmox_pkg::OP_XWR_DP) begin
          next_low_port_out = acc;
          next_wr_n = 1'b0;
        end else begin
          next_low_port_out = low_port_out;
          next_low_port_oe_n = 1'b1;
          next_rd_n = 1'b0;
        end
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else if (pin_s2 == pin_s3) begin
          if (!wr_n || !rd_n) begin
            next_rd_n = 1'b1;
            next_wr_n = 1'b1;
            next_low_port_oe_n = 1'b0;
            next_low_port_out = lp_latch;
            next_high_port_out = hp_latch;
            if (!rd_n) next_acc = pin_s3;
            next_pc = pc + 16'h0001;
            next_done = 1'b1;
            next_instr_ready = 1'b1;
            next_state = mmox_pkg::S_IDLE;
          end
        end
      end
      default: next_state = mmox_pkg::S_IDLE;
    endcase
    if (wi_en && 32'(wi_a) < RAM_DEPTH) next_ram[AW'(wi_a)] = wi_v;
    if (wd_en) begin
      unique case (wd_a)
        `SFR_ACC: next_acc = wd_v;
        `SFR_B: next_aux_b = wd_v;
        `SFR_PSW: next_psw = wd_v;
        `SFR_DPL: next_data_pointer[7:0] = wd_v;
        `SFR_DPH: next_data_pointer[15:8] = wd_v;
        `SFR_LOW_PORT: begin
          next_lp_latch = wd_v;
          next_low_port_out = wd_v;
        end
        `SFR_HIGH_PORT: begin
          next_hp_latch = wd_v;
          next_high_port_out = wd_v;
        end
        default: if (!wd_a[7] && 32'(wd_a) < RAM_DEPTH) next_ram[AW'(wd_a)] = wd_v;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= mmox_pkg::S_IDLE;
      ir <= '0;
      for (int i = 0; i < RAM_DEPTH; i++) ram[i] <= 8'h00;
      lp_latch <= 8'hff;
      hp_latch <= 8'hff;
      cnt <= 4'h0;
      acc <= 8'h00;
      aux_b <= 8'h00;
      psw <= `PSW_RESET;
      data_pointer <= 16'h0000;
      pc <= 16'h0000;
      instr_ready <= 1'b0;
      done <= 1'b0;
      illegal <= 1'b0;
      code_rd <= 1'b0;
      code_addr <= 16'h0000;
      low_port_out <= 8'hff;
      low_port_oe_n <= 1'b0;
      high_port_out <= 8'hff;
      addr_latch <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
    end else begin
      state <= next_state;
      ir <= next_ir;
      ram <= next_ram;
      lp_latch <= next_lp_latch;
      hp_latch <= next_hp_latch;
      cnt <= next_cnt;
      acc <= next_acc;
      aux_b <= next_aux_b;
      psw <= next_psw;
      data_pointer <= next_data_pointer;
      pc <= next_pc;
      instr_ready <= next_instr_ready;
      done <= next_done;
      illegal <= next_illegal;
      code_rd <= next_code_rd;
      code_addr <= next_code_addr;
      low_port_out <= next_low_port_out;
      low_port_oe_n <= next_low_port_oe_n;
      high_port_out <= next_high_port_out;
      addr_latch <= next_addr_latch;
      rd_n <= next_rd_n;
      wr_n <= next_wr_n;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  logic go;
  assign go = instr_valid && instr_ready;
  sequence s_take(logic [7:0] o);
    go && instr.opcode == o;
  endsequence
  property p_mul_time;
    @(posedge clk_sys) disable iff (!rst_n) s_take(`OPC_MUL) |=> !done [*4] ##1 done;
  endproperty
  a_mul_time: assert property (p_mul_time) else $error("multiply timing");
  property p_mul_val;
    @(posedge clk_sys) disable iff (!rst_n)
      s_take(`OPC_MUL) ##4 1'b1 |=> {aux_b, acc} == $past(acc, 5) * $past(aux_b, 5);
  endproperty
  a_mul_val: assert property (p_mul_val) else $error("multiply value");
  property p_mul_flags;
    @(posedge clk_sys) disable iff (!rst_n)
      s_take(`OPC_MUL) ##5 1'b1 |-> !psw[`PSW_CY] && psw[`PSW_OV] == (aux_b != 8'h00);
  endproperty
  a_mul_flags: assert property (p_mul_flags) else $error("multiply flags");
  property p_nop;
    @(posedge clk_sys) disable iff (!rst_n)
      s_take(`OPC_NOP) ##2 1'b1 |-> done && pc == $past(pc, 2) + 16'h0001 && acc == $past(acc, 2)
        && psw == $past(psw, 2);
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation effect");
  property p_dp;
    @(posedge clk_sys) disable iff (!rst_n)
      s_take(`OPC_MOV_DP) ##2 1'b1 |=> done && data_pointer == {$past(ir.byte1), $past(ir.byte2)};
  endproperty
  a_dp: assert property (p_dp) else $error("pointer load");
  property p_or_imm;
    @(posedge clk_sys) disable iff (!rst_n)
      s_take(`OPC_OR_A_IMM) ##2 1'b1 |-> done && acc == ($past(acc, 2) | $past(instr.byte1, 2))
        && psw == $past(psw, 2);
  endproperty
  a_or_imm: assert property (p_or_imm) else $error("or immediate");
  property p_or_di_time;
    @(posedge clk_sys) disable iff (!rst_n) s_take(`OPC_OR_DIR_IMM) |=> !done [*2] ##1 done;
  endproperty
  a_or_di_time: assert property (p_or_di_time) else $error("or direct immediate timing");
  property p_hp_latch;
    @(posedge clk_sys) disable iff (!rst_n) addr_latch |-> hp_latch == $past(hp_latch);
  endproperty
  a_hp_latch: assert property (p_hp_latch) else $error("high port latch moved");
  property p_xdp_addr;
    @(posedge clk_sys) disable iff (!rst_n)
      s_take(`OPC_XWR_DP) ##1 1'b1 |=> addr_latch && high_port_out == data_pointer[15:8]
        && low_port_out == data_pointer[7:0] && !low_port_oe_n;
  endproperty
  a_xdp_addr: assert property (p_xdp_addr) else $error("external address phase");
  property p_code_pc;
    @(posedge clk_sys) disable iff (!rst_n)
      s_take(`OPC_CODE_PC) |=> code_rd && code_addr == $past(pc) + 16'h0001 + $past(acc);
  endproperty
  a_code_pc: assert property (p_code_pc) else $error("code load address");
endmodule

// ===== core/mmox_defs.svh
`ifndef MMOX_DEFS_SVH
`define MMOX_DEFS_SVH
// opcodes
`define OPC_MOV_IR_DIR 8'ha6
`define OPC_MOV_IR_IMM 8'h76
`define OPC_MOV_C_BIT 8'ha3
`define OPC_MOV_BIT_C 8'h92
`define OPC_MOV_DP 8'h90
`define OPC_CODE_DP 8'h93
`define OPC_CODE_PC 8'h83
`define OPC_XRD_RI 8'he2
`define OPC_XRD_DP 8'he0
`define OPC_XWR_RI 8'hf2
`define OPC_XWR_DP 8'hf0
`define OPC_MUL 8'ha4
`define OPC_NOP 8'h00
`define OPC_OR_A_RN 8'h48
`define OPC_OR_A_DIR 8'h45
`define OPC_OR_A_RI 8'h46
`define OPC_OR_A_IMM 8'h44
`define OPC_OR_DIR_A 8'h42
`define OPC_OR_DIR_IMM 8'h43
`define MASK_RI 8'hfe
`define MASK_RN 8'hf8
// special byte addresses
`define SFR_LOW_PORT 8'h80
`define SFR_DPL 8'h82
`define SFR_DPH 8'h83
`define SFR_HIGH_PORT 8'ha0
`define SFR_PSW 8'hd0
`define SFR_ACC 8'he0
`define SFR_B 8'hf0
`define BIT_RAM_BASE 8'h20
// status word fields
`define PSW_CY 7
`define PSW_OV 2
`define PSW_RS_HI 4
`define PSW_RS_LO 3
`define PSW_RESET 8'h00
// external strobe length in cycles
`define XM_STROBE 4'h3
`endif

// ===== core/mmox_pkg.sv
package mmox_pkg;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_WAIT = 5'b00010,
    S_CODE = 5'b00100,
    S_XADR = 5'b01000,
    S_XDAT = 5'b10000
  } mmox_state_t;
  typedef enum logic [4:0] {
    OP_BAD, OP_IR_DIR, OP_IR_IMM, OP_C_BIT, OP_BIT_C, OP_DP,
    OP_CODE_DP, OP_CODE_PC, OP_XRD_RI, OP_XRD_DP, OP_XWR_RI,
    OP_XWR_DP, OP_MUL, OP_NOP, OP_OR_RN, OP_OR_DIR, OP_OR_RI,
    OP_OR_IMM, OP_OR_DA, OP_OR_DI
  } mmox_op_t;
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } mmox_instr_t;
endpackage

// ===== test/mmox_xmem.sv
`timescale 1ns/100ps
// external data memory on the multiplexed low port
module mmox_xmem (
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic addr_latch,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic low_port_oe_n,
  input wire logic [7:0] low_port_out,
  input wire logic [7:0] high_port_out,
  output logic [7:0] low_port_in
);
  logic [7:0] mem [0:65535];
  logic [15:0] addr = 16'h0000;
  logic [7:0] last = 8'h00;
  logic [1:0] cnt = 2'h0;
  logic drv = 1'b0;
  initial begin
    for (int k = 0; k < 65536; k++) mem[k] = k[7:0] ^ k[15:8] ^ 8'h5a;
  end
  always @(posedge clk_sys) begin
    if (addr_latch) addr <= {high_port_out, low_port_out};
    if (!wr_n) mem[addr] <= low_port_out;
    cnt <= rd_n ? 2'h0 : (cnt == 2'h3 ? cnt : cnt + 2'h1);
    drv <= !rd_n && (!slow || cnt >= 2'h2);
    last <= low_port_in;
  end
  // undriven lines show a pattern that changes every cycle
  assign low_port_in = !low_port_oe_n ? low_port_out : (drv ? mem[addr] : ~last);
endmodule

// ===== test/testbench.sv
`timescale 1ns/100ps
`include "mmox_defs.svh"
module testbench;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic instr_valid = 1'b0;
  mmox_pkg::mmox_instr_t instr = '0;
  logic code_valid = 1'b0;
  logic [7:0] code_data = 8'h00;
  logic xslow = 1'b0;
  logic instr_ready, done, illegal, code_rd, low_port_oe_n, addr_latch, rd_n, wr_n, cv;
  logic [15:0] code_addr, data_pointer, pc;
  logic [7:0] low_port_out, low_port_in, high_port_out, acc, aux_b, psw;
  int err_count = 0;
  int checks = 0;
  int seed = 13;
  int cd = 0;
  logic [7:0] r [0:127];
  logic [7:0] xm [logic [15:0]];
  logic [7:0] ma = 8'h00, mb = 8'h00, lo_l = 8'hff, hi_l = 8'hff, elo, ehi;
  logic [15:0] mdp = 16'h0000, mpc = 16'h0000, eca;
  logic cy = 1'b0, ov = 1'b0, ill;
  logic [31:0] v;
  logic [7:0] op;
  logic [7:0] ops [0:18] = '{`OPC_MOV_IR_DIR, `OPC_MOV_IR_IMM, `OPC_MOV_C_BIT, `OPC_MOV_BIT_C, `OPC_MOV_DP,
    `OPC_CODE_DP, `OPC_CODE_PC, `OPC_XRD_RI, `OPC_XRD_DP, `OPC_XWR_RI, `OPC_XWR_DP, `OPC_MUL, `OPC_NOP,
    `OPC_OR_A_RN, `OPC_OR_A_DIR, `OPC_OR_A_RI, `OPC_OR_A_IMM, `OPC_OR_DIR_A, `OPC_OR_DIR_IMM};
  logic [23:0] dir [0:28] = '{24'h901234, 24'h445000, 24'h43f0a0, 24'ha40000, 24'ha40000, 24'h930000,
    24'h830000, 24'h774100, 24'h765500, 24'ha6e000, 24'h460000, 24'h4341aa, 24'h454100, 24'h423000,
    24'h4320ff, 24'ha30500, 24'h920f00, 24'ha40000, 24'h92a300, 24'h928500, 24'h438000, 24'h43a001,
    24'hf00000, 24'he00000, 24'hf30000, 24'he30000, 24'ha50000, 24'h000000, 24'h4b0000};

  initial forever #20 clk_sys = ~clk_sys;

  mmox_core #(.RAM_DEPTH(128)) i_mmox_core (.clk_sys, .resetn, .instr_valid, .instr, .instr_ready, .done,
    .illegal, .code_rd, .code_addr, .code_valid, .code_data, .low_port_out, .low_port_oe_n, .low_port_in,
    .high_port_out, .addr_latch, .rd_n, .wr_n, .acc, .aux_b, .psw, .data_pointer, .pc);
  mmox_xmem i_mmox_xmem (.clk_sys, .slow(xslow), .addr_latch, .rd_n, .wr_n, .low_port_oe_n,
    .low_port_out, .high_port_out, .low_port_in);

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  function automatic logic [7:0] cf(input logic [15:0] a);
    return a[7:0] ^ {a[14:8], a[15]};
  endfunction

  function automatic logic [7:0] rdd(input logic [7:0] a);
    case (a)
      `SFR_ACC: return ma;
      `SFR_B: return mb;
      `SFR_DPL: return mdp[7:0];
      `SFR_DPH: return mdp[15:8];
      `SFR_LOW_PORT: return lo_l;
      `SFR_HIGH_PORT: return hi_l;
      default: return a[7] ? 8'h00 : r[a[6:0]];
    endcase
  endfunction

  task automatic wrd(input logic [7:0] a, input logic [7:0] d);
    case (a)
      `SFR_ACC: ma = d;
      `SFR_B: mb = d;
      `SFR_LOW_PORT: lo_l = d;
      `SFR_HIGH_PORT: hi_l = d;
      default: if (!a[7]) r[a[6:0]] = d;
    endcase
  endtask

  function automatic logic [7:0] ba(input logic [7:0] a);
    return a[7] ? {a[7:3], 3'h0} : `BIT_RAM_BASE + {4'h0, a[6:3]};
  endfunction

  // reference behaviour of one instruction
  task automatic step(input logic [7:0] o, input logic [7:0] b1, input logic [7:0] b2, output int n,
      output int len);
    logic [7:0] p, t;
    logic [15:0] pr;
    p = r[{6'h0, o[0]}];
    t = rdd(ba(b1));
    n = 1;
    len = (o == `OPC_MOV_DP || o == `OPC_OR_DIR_IMM) ? 3 : 2;
    ill = 1'b0;
    if ((o & `MASK_RN) == `OPC_OR_A_RN || (o & 8'hec) == 8'he0 || o == `OPC_MUL || o == `OPC_NOP ||
        (o & 8'hef) == 8'h83 || (o & `MASK_RI) == `OPC_OR_A_RI) len = 1;
    if ((o & `MASK_RN) == `OPC_OR_A_RN) ma = ma | r[{4'h0, o[2:0]}];
    else if ((o & `MASK_RI) == `OPC_OR_A_RI) ma = ma | (p[7] ? 8'h00 : r[p[6:0]]);
    else if ((o & `MASK_RI) == `OPC_MOV_IR_DIR) begin
      if (!p[7]) r[p[6:0]] = rdd(b1);
      n = 2;
    end else if ((o & `MASK_RI) == `OPC_MOV_IR_IMM) begin
      if (!p[7]) r[p[6:0]] = b1;
    end else if ((o & 8'hec) == 8'he0) begin
      pr = o[1] ? {hi_l, p} : mdp;
      elo = pr[7:0];
      ehi = pr[15:8];
      n = 0;
      if (o[4]) xm[pr] = ma;
      else ma = xm.exists(pr) ? xm[pr] : pr[7:0] ^ pr[15:8] ^ 8'h5a;
    end else if ((o & 8'hef) == 8'h83) begin
      eca = {8'h00, ma} + (o[4] ? mdp : mpc + 16'h0001);
      ma = cf(eca);
      n = 0;
    end else begin
      case (o)
        `OPC_MOV_C_BIT: cy = t[b1[2:0]];
        `OPC_MOV_BIT_C: begin
          t[b1[2:0]] = cy;
          wrd(ba(b1), t);
          n = 2;
        end
        `OPC_MOV_DP: begin
          mdp = {b1, b2};
          n = 2;
        end
        `OPC_MUL: begin
          pr = ma * mb;
          {mb, ma} = pr;
          ov = |pr[15:8];
          cy = 1'b0;
          n = 4;
        end
        `OPC_NOP: n = 1;
        `OPC_OR_A_DIR: ma = ma | rdd(b1);
        `OPC_OR_A_IMM: ma = ma | b1;
        `OPC_OR_DIR_A: wrd(b1, rdd(b1) | ma);
        `OPC_OR_DIR_IMM: begin
          wrd(b1, rdd(b1) | b2);
          n = 2;
        end
        default: begin
          ill = 1'b1;
          len = 1;
        end
      endcase
    end
    mpc = mpc + 16'(len);
  endtask

  task automatic run(input logic [23:0] w);
    int n, len, m;
    logic il;
    step(w[23:16], w[15:8], w[7:0], n, len);
    while (instr_ready !== 1'b1) @(negedge clk_sys);
    instr = w;
    instr_valid = 1'b1;
    xslow = 1'($random(seed));
    @(negedge clk_sys);
    instr_valid = 1'b0;
    m = 0;
    do begin
      @(negedge clk_sys);
      m++;
      il = illegal;
    end while (done !== 1'b1 && m < 40);
    chk(done, 1);
    chk(il, ill);
    if (n > 0) chk(m, n);
    chk(acc, ma);
    chk(aux_b, mb);
    chk({psw[7], psw[2], psw[4:3]}, {cy, ov, 2'b00});
    chk(data_pointer, mdp);
    chk(pc, mpc);
    chk(high_port_out, hi_l);
    chk(low_port_out, lo_l);
    chk({instr_ready, rd_n, wr_n, low_port_oe_n, addr_latch}, 16'h001c);
  endtask

  always @(negedge clk_sys) begin
    cv = 1'b0;
    if (addr_latch) begin
      chk(low_port_out, elo);
      chk(high_port_out, ehi);
    end
    if (code_rd) begin
      chk(code_addr, eca);
      cd = 2;
    end else if (cd > 0) begin
      cd--;
      cv = (cd == 0);
    end
    code_valid = cv;
    code_data = cv ? cf(code_addr) : ~code_data;
  end

  initial begin
    for (int k = 0; k < 128; k++) r[k] = 8'h00;
    repeat (6) @(negedge clk_sys);
    chk(instr_ready, 0);
    chk(high_port_out, 8'hff);
    resetn = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(instr_ready, 1);
    for (int k = 0; k < 29; k++) run(dir[k]);
    for (int k = 0; k < 300; k++) begin
      v = $random(seed);
      op = ops[v[7:0] % 19];
      if ((op & `MASK_RN) == `OPC_OR_A_RN) op = op | {5'h00, v[18:16]};
      else if ((op & 8'h0e) == 8'h06 || (op & 8'hee) == 8'he2) op = op | {7'h00, v[16]};
      run({op, 8'h20 + (v[15:8] % 8'd96), v[31:24]});
    end
    print_verdict;
  end

  initial begin
    #2000000;
    err_count++;
    print_verdict;
  end
endmodule
